// *** hbsp_pkg.sv ***
// Purpose: Shared types and constants for the handler bin sort port.
// Assumes: One clock domain; handler pins are idle high.
// Notes:   Bin indices count from zero here, so bin output 1 is bit 0.
`default_nettype none
package hbsp_pkg;

   // Number of sorting outputs and of sequence steps that own a bin.
   localparam int unsigned BIN_COUNT      = 14;
   localparam int unsigned SEQ_STEPS      = 6;
   // Synchroniser depth for handler inputs.
   localparam int unsigned SYNC_STAGES    = 3;
   // Reset value of the bin pattern: nothing sorted.
   localparam logic [13:0] BINS_RESET     = 14'h0000;
   // Bit positions of the fixed-purpose bins.
   localparam int unsigned BIN_ALL_PASS   = 0;
   localparam int unsigned BIN_SEC_LOW    = 10;
   localparam int unsigned BIN_SEC_HIGH   = 11;
   localparam int unsigned BIN_PRI_FAIL   = 12;
   localparam int unsigned BIN_BOTH_FAIL  = 13;
   // Highest primary bin number that a pass may name.
   localparam logic [3:0]  PRI_BIN_MAX    = 4'hA;
   // Step code for a sequence in which every step passed.
   localparam logic [2:0]  STEP_ALL_PASS  = 3'h0;

   // Trigger source chosen by the instrument.
   typedef enum logic {
      HBSP_TRIG_INTERNAL = 1'b0,
      HBSP_TRIG_EXTERNAL = 1'b1
   } hbsp_trig_t;

   // Judgement delivered by the measurement core with its done pulse.
   typedef struct packed {
      logic       seq_mode;       // Result of a sequence test.
      logic [2:0] fail_step;      // First failing step, zero when all pass.
      logic       pri_pass;       // Primary parameter inside limits.
      logic [3:0] pri_bin;        // Primary bin number 1 to 10.
      logic       pri_limits_off; // All primary bin limits set to off.
      logic       bin_enable;     // Binning enabled.
      logic       sec_pass;       // Secondary parameter inside limits.
      logic       sec_fail_high;  // Secondary above its upper limit.
   } hbsp_result_t;

   // Open-drain drive of the handler outputs.
   typedef struct packed {
      logic        busy_oe;
      logic        test_complete_oe;
      logic [13:0] bin_oe;
   } hbsp_drive_t;

endpackage
`default_nettype wire

// *** hbsp_sync.sv ***
// Purpose: Synchronise one active-low handler input and flag its fall.
// Assumes: The input is asynchronous to clk and idles high.
// Notes:   The level counts only when the last two stages agree.
`timescale 1ns/1ps
`default_nettype none
module hbsp_sync
   import hbsp_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic reset_n,
   // Pin and result.
   input  wire logic pin_n,
   output logic      fall_pulse
);

   logic [SYNC_STAGES-1:0] stage_reg;
   logic                   level_reg;

   // Shift chain; stage zero feeds only stage one to avoid metastable fan-out.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= '1;
      end else begin
         stage_reg <= {stage_reg[SYNC_STAGES-2:0], pin_n};
      end
   end

   // Filtered level moves once the two late stages agree.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_reg  <= 1'b1;
         fall_pulse <= 1'b0;
      end else begin
         fall_pulse <= 1'b0;
         if (stage_reg[1] == stage_reg[2]) begin
            level_reg <= stage_reg[2];
            // Only the high-to-low change fires, so a held low triggers once.
            if (level_reg && !stage_reg[2]) begin
               fall_pulse <= 1'b1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** hbsp_port.sv ***
// Purpose: Handler port: start and stop inputs, busy, end-of-test and bin outputs.
// Assumes: The measurement core answers each start with a done or an abort.
// Notes:   Outputs are open drain; a pin is pulled low only while its enable is high.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Outputs pull low when active, float otherwise.
// - Start and stop inputs are active low.
// - Busy held during measurement; bins on outputs.
// - End-of-test goes low at completion.
// - Start input launches a measurement.
// - Stop input ends a running measurement.
// - Bin 1 primary, secondary-only, or sequence pass.
// - Bins 2-7 primary or step fail; 8-10 primary.
// - Bins 11/12: secondary fails low/high.
// - Bin 13 primary fail; 14 both fail.
// - External trigger: one measurement per start.
// - Internal trigger: repeat until stop.
module hbsp_port
   import hbsp_pkg::*;
(
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         reset_n,
   // Handler pins, active low.
   input  wire logic         start_n,
   input  wire logic         stop_n,
   // Open-drain outputs: level and enables.
   output logic              pin_level,
   output hbsp_drive_t       drive,
   // Instrument configuration.
   input  wire hbsp_trig_t   trig_mode,
   // Measurement core.
   output logic              meas_start,
   output logic              meas_abort,
   input  wire logic         meas_done,
   input  wire hbsp_result_t meas_result
);

   typedef enum logic [1:0] {
      HBSP_IDLE = 2'b00,
      HBSP_MEAS = 2'b01,
      HBSP_SHOW = 2'b10
   } hbsp_state_t;

   hbsp_state_t state_reg;
   logic        start_fall;
   logic        stop_fall;
   logic        busy_reg;
   logic        test_complete_reg;
   logic [13:0] bins_reg;

   // Map a judgement onto the fourteen sorting outputs.
   function automatic logic [13:0] hbsp_decode(input hbsp_result_t r);
      logic [13:0] b;
      b = BINS_RESET;
      if (r.seq_mode) begin
         if (r.fail_step == STEP_ALL_PASS) begin
            b[BIN_ALL_PASS] = 1'b1;
         end else if (r.fail_step <= 3'(SEQ_STEPS)) begin
            b[r.fail_step] = 1'b1;
         end
      end else if (r.bin_enable && r.pri_limits_off) begin
         if (r.sec_pass) begin
            b[BIN_ALL_PASS] = 1'b1;
         end else begin
            b[BIN_BOTH_FAIL] = 1'b1;
         end
      end else if (r.pri_pass) begin
         if (!r.sec_pass && r.sec_fail_high) begin
            b[BIN_SEC_HIGH] = 1'b1;
         end else if (!r.sec_pass) begin
            b[BIN_SEC_LOW] = 1'b1;
         end else if (r.pri_bin != 4'h0 && r.pri_bin <= PRI_BIN_MAX) begin
            b[r.pri_bin - 4'h1] = 1'b1;
         end
      end else if (r.sec_pass) begin
         b[BIN_PRI_FAIL] = 1'b1;
      end else begin
         b[BIN_BOTH_FAIL] = 1'b1;
      end
      return b;
   endfunction

   // Start and stop arrive from the handler, outside the clock domain.
   hbsp_sync u_start_sync (
      .clk        (clk),
      .reset_n    (reset_n),
      .pin_n      (start_n),
      .fall_pulse (start_fall)
   );

   hbsp_sync u_stop_sync (
      .clk        (clk),
      .reset_n    (reset_n),
      .pin_n      (stop_n),
      .fall_pulse (stop_fall)
   );

   // Sequencer. Stop has priority over a done in the same cycle, so an aborted
   // measurement never reports a judgement it may not have finished.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= HBSP_IDLE;
         meas_start <= 1'b0;
         meas_abort <= 1'b0;
      end else begin
         meas_start <= 1'b0;
         meas_abort <= 1'b0;
         case (state_reg)
            HBSP_IDLE: begin
               if (start_fall && !stop_fall) begin
                  state_reg  <= HBSP_MEAS;
                  meas_start <= 1'b1;
               end
            end
            HBSP_MEAS: begin
               // A start during a measurement is ignored: one run per start with the external trigger.
               if (stop_fall) begin
                  state_reg  <= HBSP_IDLE;
                  meas_abort <= 1'b1;
               end else if (meas_done) begin
                  state_reg <= (trig_mode == HBSP_TRIG_INTERNAL) ? HBSP_SHOW
                                                                : HBSP_IDLE;
               end
            end
            HBSP_SHOW: begin
               // One cycle of shown result before the next internal run.
               if (stop_fall) begin
                  state_reg <= HBSP_IDLE;
               end else begin
                  state_reg  <= HBSP_MEAS;
                  meas_start <= 1'b1;
               end
            end
            default: begin
               state_reg <= HBSP_IDLE;
            end
         endcase
      end
   end

   // True in the cycle the sequencer issues a start.
   function automatic logic meas_start_next();
      return (state_reg == HBSP_IDLE && start_fall && !stop_fall) ||
             (state_reg == HBSP_SHOW && !stop_fall);
   endfunction

   // Busy follows the measurement itself; enable high pulls the pin low.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (state_reg == HBSP_MEAS) ? !(meas_done || stop_fall)
                                              : meas_start_next();
      end
   end

   // Judgement and end-of-test: cleared on a new start, set together at done.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bins_reg          <= BINS_RESET;
         test_complete_reg <= 1'b0;
      end else if (meas_start_next()) begin
         bins_reg          <= BINS_RESET;
         test_complete_reg <= 1'b0;
      end else if (state_reg == HBSP_MEAS && meas_done && !stop_fall) begin
         bins_reg          <= hbsp_decode(meas_result);
         test_complete_reg <= 1'b1;
      end
   end

   // Each enable lives in its own flop and the struct only bundles them for the
   // port, so every field keeps a single writer.
   assign drive = '{busy_oe:          busy_reg,
                    test_complete_oe: test_complete_reg,
                    bin_oe:           bins_reg};

   // Open-drain pins only ever drive low.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_level <= 1'b0;
      end else begin
         pin_level <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_PIN_LOW: assert property (pin_level == 1'b0)
      else $error("Handler pin level not low.");
   // Busy rises on the same edge as the start request, so a core that answers
   // at once still sees a consistent pin.
   AST_BUSY_START: assert property (meas_start |-> drive.busy_oe)
      else $error("Busy not asserted with start.");
   AST_BUSY_HELD: assert property
      (state_reg == HBSP_MEAS && !meas_done && !stop_fall |=> drive.busy_oe)
      else $error("Busy dropped during a measurement.");
   AST_START_FROM_PIN: assert property
      ($rose(meas_start) && $past(state_reg) == HBSP_IDLE |-> $past(start_fall))
      else $error("Measurement started without a start edge.");
   AST_STOP_ENDS: assert property
      (state_reg == HBSP_MEAS && stop_fall |=> state_reg == HBSP_IDLE && meas_abort
       && !drive.busy_oe)
      else $error("Stop did not end the measurement.");
   AST_EOT_DONE: assert property
      (state_reg == HBSP_MEAS && meas_done && !stop_fall |=> drive.test_complete_oe
       && !drive.busy_oe)
      else $error("End of test missing at completion.");
   AST_CLEAR_ON_START: assert property
      (meas_start |-> drive.bin_oe == BINS_RESET && !drive.test_complete_oe)
      else $error("Outputs not cleared at new start.");
   // A fresh handler start right after done is legal, so only the automatic
   // restart is ruled out here.
   AST_ONE_SHOT: assert property
      (state_reg == HBSP_MEAS && meas_done && !stop_fall
       && trig_mode == HBSP_TRIG_EXTERNAL |=> state_reg == HBSP_IDLE && !meas_start)
      else $error("External trigger ran more than once.");
   AST_REPEAT: assert property
      (state_reg == HBSP_MEAS && meas_done && !stop_fall
       && trig_mode == HBSP_TRIG_INTERNAL |=> ##1 (meas_start || state_reg == HBSP_IDLE))
      else $error("Internal trigger did not repeat.");
   AST_ONE_BIN: assert property ($onehot0(drive.bin_oe))
      else $error("More than one bin active.");
   AST_SEQ_STEP: assert property
      (state_reg == HBSP_MEAS && meas_done && !stop_fall && meas_result.seq_mode
       && meas_result.fail_step == 3'h3 |=> drive.bin_oe[3])
      else $error("Sequence step failure on wrong bin.");

endmodule
`default_nettype wire

// *** hbsp_handler.sv ***
// Purpose: Handler model that drives the start and stop pins.
// Assumes: Pins have external pull-ups, so a released pin reads high.
// Notes:   Each press is held for several cycles so the synchroniser sees it.
`timescale 1ns/1ps
`default_nettype none
module hbsp_handler (
   // Clock.
   input  wire logic clk,
   // Handler pins, active low.
   output logic      start_n,
   output logic      stop_n
);
   // Pins idle high through reset, as the pull-ups hold them.
   initial begin
      start_n = 1'b1;
      stop_n  = 1'b1;
   end

   // Pull one pin low, hold it, then release it and let it settle high.
   task automatic press(input bit is_stop, input int hold);
      @(negedge clk);
      if (is_stop) begin
         stop_n = 1'b0;
      end else begin
         start_n = 1'b0;
      end
      repeat (hold) @(negedge clk);
      start_n = 1'b1;
      stop_n  = 1'b1;
      // A return to high must be seen before the next fall counts.
      repeat (3) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// *** hbsp_port_tb_top.sv ***
// Purpose: Self-checking bench for the handler port.
// Assumes: The bench plays the measurement core and drives at the falling edge.
// Notes:   Expected bins come from a behavioural decode of each judgement.
`timescale 1ns/1ps
`default_nettype none
module hbsp_port_tb_top;
   import hbsp_pkg::*;
   logic         clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         start_n;
   logic         stop_n;
   logic         pin_level;
   logic         meas_start;
   logic         meas_abort;
   logic         meas_done = 1'b0;
   hbsp_drive_t  drive;
   hbsp_trig_t   trig_mode = HBSP_TRIG_EXTERNAL;
   hbsp_result_t meas_result = '0;
   hbsp_result_t r;
   int           n_errors = 0;
   int           compares = 0;
   int           n_starts = 0;
   int           n_aborts = 0;
   int           s0;
   int           seed = 32'h2f1f68bf;

   // Free-running clock.
   always #5 clk = ~clk;

   hbsp_handler hbsp_handler_inst (.clk(clk), .start_n(start_n), .stop_n(stop_n));
   hbsp_port hbsp_port_inst (.clk(clk), .reset_n(reset_n), .start_n(start_n),
      .stop_n(stop_n), .pin_level(pin_level), .drive(drive), .trig_mode(trig_mode),
      .meas_start(meas_start), .meas_abort(meas_abort), .meas_done(meas_done),
      .meas_result(meas_result));

   // Count core requests so repeated or missing starts show up.
   always @(posedge clk) begin
      if (meas_start === 1'b1) n_starts++;
      if (meas_abort === 1'b1) n_aborts++;
   end

   // Behavioural decode of a judgement into the one bin expected, if any.
   function automatic logic [13:0] ref_bins(input hbsp_result_t x);
      int b;
      b = -1;
      if (x.seq_mode) b = (x.fail_step < 3'h7) ? int'(x.fail_step) : -1;
      else if (x.bin_enable && x.pri_limits_off) b = x.sec_pass ? 0 : BIN_BOTH_FAIL;
      else if (x.pri_pass && !x.sec_pass) b = x.sec_fail_high ? BIN_SEC_HIGH : BIN_SEC_LOW;
      else if (x.pri_pass) b = (x.pri_bin >= 4'h1 && x.pri_bin <= PRI_BIN_MAX) ? x.pri_bin - 1 : -1;
      else b = x.sec_pass ? BIN_PRI_FAIL : BIN_BOTH_FAIL;
      return (b < 0) ? 14'h0000 : (14'h0001 << b);
   endfunction

   // Random judgement; a fail-high flag is only meaningful on a secondary fail.
   function automatic hbsp_result_t rand_result();
      logic [31:0]  v;
      hbsp_result_t x;
      v = $random(seed);
      x = v[12:0];
      x.sec_fail_high = x.sec_fail_high & ~x.sec_pass;
      return x;
   endfunction

   task automatic check_vec(input logic [13:0] got, input logic [13:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_int(input int got, input int exp);
      check_vec(got[13:0], exp[13:0]);
   endtask

   // Wait, bounded, for the request to the core.
   task automatic wait_start();
      for (int i = 0; i < 30 && meas_start !== 1'b1; i++) @(negedge clk);
      check_vec({13'h0, meas_start}, 14'h0001);
   endtask

   task automatic start_meas(input int hold);
      fork
         hbsp_handler_inst.press(1'b0, hold);
         wait_start();
      join
   endtask

   // Deliver one judgement with a single done pulse.
   task automatic finish(input hbsp_result_t x);
      @(negedge clk);
      meas_done = 1'b1;
      meas_result = x;
      @(negedge clk);
      meas_done = 1'b0;
   endtask

   task automatic test_done();
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the roughly 2100 cycles the tests take.
   initial begin
      #500000;
      n_errors++;
      test_done();
   end

   // Main sequence.
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      check_vec({13'h0, pin_level}, 14'h0000);
      for (int i = 0; i < 80; i++) begin
         r = rand_result();
         s0 = n_starts;
         start_meas(3 + i % 10);
         check_vec({13'h0, drive.busy_oe}, 14'h0001);
         check_vec(drive.bin_oe, 14'h0000);
         check_vec({13'h0, drive.test_complete_oe}, 14'h0000);
         if (i % 4 == 0) hbsp_handler_inst.press(1'b0, 4);
         finish(r);
         check_vec(drive.bin_oe, ref_bins(r));
         check_vec({13'h0, drive.test_complete_oe}, 14'h0001);
         check_vec({13'h0, drive.busy_oe}, 14'h0000);
         repeat (10) @(negedge clk);
         check_int(n_starts, s0 + 1);
      end
      // Stop in mid-measurement aborts without an end-of-test.
      start_meas(4);
      s0 = n_aborts;
      hbsp_handler_inst.press(1'b1, 4);
      check_int(n_aborts, s0 + 1);
      check_vec({13'h0, drive.busy_oe}, 14'h0000);
      check_vec({13'h0, drive.test_complete_oe}, 14'h0000);
      // Internal trigger repeats until a stop arrives.
      trig_mode = HBSP_TRIG_INTERNAL;
      start_meas(4);
      for (int k = 0; k < 3; k++) begin
         r = rand_result();
         finish(r);
         // The judgement stands for the single cycle before the restart.
         check_vec(drive.bin_oe, ref_bins(r));
         check_vec({13'h0, drive.test_complete_oe}, 14'h0001);
         wait_start();
         check_vec(drive.bin_oe, 14'h0000);
      end
      hbsp_handler_inst.press(1'b1, 4);
      s0 = n_starts;
      repeat (20) @(negedge clk);
      check_int(n_starts, s0);
      check_vec({13'h0, drive.busy_oe}, 14'h0000);
      test_done();
   end
endmodule
`default_nettype wire
